/* File: rtl/pds_pwm_out.sv */
/*
  PWM output stage: period timer, duty compare, half-bridge dead band,
  single-output pulse steering, auto-shutdown with restart, power modes,
  and a Wishbone classic register slave with interrupts.
  Assumes synchronous pin inputs on MCLK and a 32-bit Wishbone master.
*/
`timescale 1ns/1ps
`include "pds_consts.svh"

module pds_pwm_out #(
  parameter int LP_DIV = 8
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // Wishbone classic slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK,
  // System
  input  wire logic [1:0]  POWER_MODE,
  input  wire logic        SHUTDOWN_IN,
  input  wire logic [3:0]  PORT_LATCH,
  // Pins
  output logic [3:0]       PWM_OUT,
  output logic [3:0]       PWM_OE,
  // Interrupt
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic       auto_restart_enable;
  logic [6:0] deadband_count;
  logic       steer_sync_select;
  logic [3:0] steer_req;
  logic [3:0] steer_act;
  logic [1:0] module_mode_upper;
  logic [1:0] output_polarity_select;
  logic [1:0] output_config_select;
  logic       shutdown_status_flag;
  logic [1:0] shut_state_ac;
  logic [1:0] shut_state_bd;
  logic [7:0] period_limit;
  logic [7:0] duty;
  logic [3:0] pin_direction_control;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [7:0] period_timer_count;
  logic       held_off;

  pds_pkg::pds_power_type power;
  pds_pkg::pds_wb_req_type req;
  assign power = pds_pkg::pds_power_type'(POWER_MODE);
  assign req   = '{WB_CYC, WB_STB, WB_WE, WB_ADR, WB_SEL, WB_DAT_I};

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating by power mode
  logic run;
  logic cyc_tick;
  logic lp_tick;
  logic timer_tick;
  logic [7:0] lp_cnt;

  assign run = (power != pds_pkg::PDS_SLEEP);

  pds_cycle_div u_div (
    .clk   (MCLK),
    .rst_n (RESETN),
    .run   (run),
    .tick  (cyc_tick)
  );

  // Low-power clock is a further division of the instruction cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      lp_cnt <= 8'h00;
    end else if (cyc_tick) begin
      lp_cnt <= (lp_cnt == 8'(LP_DIV - 1)) ? 8'h00 : lp_cnt + 8'h01;
    end
  end

  assign lp_tick    = cyc_tick && (lp_cnt == 8'(LP_DIV - 1));
  assign timer_tick = (power == pds_pkg::PDS_IDLE_LP) ? lp_tick : cyc_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Period timer and duty compare
  logic period_start;
  logic sched_a;
  logic sched_b;

  assign period_start = timer_tick && (period_timer_count == period_limit);

  // Timer wraps at the limit; frozen when no tick arrives
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      period_timer_count <= 8'h00;
    end else if (timer_tick) begin
      period_timer_count <= period_start ? 8'h00 : period_timer_count + 8'h01;
    end
  end

  assign sched_a = (period_timer_count < duty);
  assign sched_b = !sched_a;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic single_mode;
  logic half_mode;

  assign single_mode = (module_mode_upper == `PDS_MODE_SINGLE)
                    && (output_config_select == `PDS_CFG_SINGLE);
  assign half_mode   = (module_mode_upper == `PDS_MODE_SINGLE)
                    && (output_config_select == 2'b10);

  ////////////////////////////////////////////////////////////////////////////
  // Dead band on the half-bridge pair
  logic db_a;
  logic db_b;

  pds_deadband u_db_a (
    .clk    (MCLK),
    .rst_n  (RESETN),
    .tick   (cyc_tick),
    .count  (deadband_count),
    .sched  (sched_a),
    .actual (db_a)
  );

  pds_deadband u_db_b (
    .clk    (MCLK),
    .rst_n  (RESETN),
    .tick   (cyc_tick),
    .count  (deadband_count),
    .sched  (sched_b),
    .actual (db_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Steering selection update
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      steer_act <= 4'(`PDS_STEER_RESET);
    end else if (!steer_sync_select) begin
      steer_act <= steer_req;
    end else if (period_start) begin
      steer_act <= steer_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown flag, restart and hold-off to next period
  logic bus_write;
  logic ase_write;
  logic ase_clr_sw;
  logic ase_set_sw;

  assign bus_write  = req.cyc && req.stb && req.we && !WB_ACK && req.sel[0];
  assign ase_write  = bus_write && (req.adr == `PDS_OFS_SHUT);
  assign ase_clr_sw = ase_write && !req.dat[`PDS_ASE_BIT] && !SHUTDOWN_IN;
  assign ase_set_sw = ase_write && req.dat[`PDS_ASE_BIT];

  // Set wins over clear; writes ignored while the condition persists
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      shutdown_status_flag <= 1'b0;
    end else if (!run) begin
      shutdown_status_flag <= shutdown_status_flag;
    end else if (SHUTDOWN_IN || ase_set_sw) begin
      shutdown_status_flag <= 1'b1;
    end else if (auto_restart_enable) begin
      shutdown_status_flag <= 1'b0;
    end else if (ase_clr_sw) begin
      shutdown_status_flag <= 1'b0;
    end
  end

  // Outputs stay off from shutdown until the following period begins
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      held_off <= 1'b0;
    end else if (shutdown_status_flag || SHUTDOWN_IN) begin
      held_off <= 1'b1;
    end else if (period_start) begin
      held_off <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin mux
  logic [3:0] wave;
  logic [3:0] use_pwm;
  logic       pol_a;
  logic       pol_b;
  logic       shut_now;

  assign shut_now = SHUTDOWN_IN || shutdown_status_flag || held_off;

  // Polarity: bit 1 inverts A and, in single mode, every steered pin; bit 0 inverts B in half-bridge mode only
  assign pol_a = output_polarity_select[1];
  assign pol_b = output_polarity_select[0];

  always_comb begin
    wave    = 4'h0;
    use_pwm = 4'h0;
    if (single_mode) begin
      wave    = {4{sched_a ^ pol_a}};
      use_pwm = steer_act;
    end else if (half_mode) begin
      wave    = {1'b0, 1'b0, db_b ^ pol_b, db_a ^ pol_a};
      use_pwm = 4'b0011;
    end
  end

  // Registered pins; sleep holds the last level
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PWM_OUT <= 4'h0;
      PWM_OE  <= 4'h0;
    end else if (run) begin
      for (int i = 0; i < 4; i++) begin
        logic [1:0] ss;
        ss = (i == 0 || i == 2) ? shut_state_ac : shut_state_bd;
        if (!use_pwm[i]) begin
          PWM_OUT[i] <= PORT_LATCH[i];
          PWM_OE[i]  <= !pin_direction_control[i];
        end else if (shut_now) begin
          PWM_OUT[i] <= (ss == `PDS_SHUT_HIGH);
          PWM_OE[i]  <= !pin_direction_control[i] && !ss[1];
        end else begin
          PWM_OUT[i] <= wave[i];
          PWM_OE[i]  <= !pin_direction_control[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      auto_restart_enable    <= 1'b0;
      deadband_count         <= 7'h00;
      steer_sync_select      <= 1'b0;
      steer_req              <= 4'(`PDS_STEER_RESET);
      module_mode_upper      <= 2'b00;
      output_polarity_select <= 2'b00;
      output_config_select   <= 2'b00;
      shut_state_ac          <= 2'b00;
      shut_state_bd          <= 2'b00;
      period_limit           <= 8'hFF;
      duty                   <= 8'h00;
      pin_direction_control  <= `PDS_DIR_RESET;
      irq_en                 <= 3'h0;
    end else if (bus_write) begin
      case (req.adr)
        `PDS_OFS_PWMCTL: begin
          auto_restart_enable <= req.dat[`PDS_RESTART_BIT];
          deadband_count      <= req.dat[6:0];
        end
        `PDS_OFS_STEER: begin
          steer_sync_select <= req.dat[`PDS_SYNC_BIT];
          steer_req         <= req.dat[3:0];
        end
        `PDS_OFS_MODE: begin
          output_config_select   <= req.dat[7:6];
          module_mode_upper      <= req.dat[3:2];
          output_polarity_select <= req.dat[1:0];
        end
        `PDS_OFS_SHUT: begin
          shut_state_ac <= req.dat[3:2];
          shut_state_bd <= req.dat[1:0];
        end
        `PDS_OFS_PERIOD:  period_limit          <= req.dat[7:0];
        `PDS_OFS_DUTY:    duty                  <= req.dat[7:0];
        `PDS_OFS_IRQ_EN:  irq_en                <= req.dat[2:0];
        `PDS_OFS_PINDIR:  pin_direction_control <= req.dat[3:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: shutdown entry, period start, shutdown exit
  logic       flag_q;
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;

  assign irq_evt = {flag_q && !shutdown_status_flag, period_start, !flag_q && shutdown_status_flag};
  assign irq_clr = (bus_write && req.adr == `PDS_OFS_IRQ_CLR) ? req.dat[2:0] : 3'h0;

  // Event set wins over a clear in the same cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      flag_q   <= 1'b0;
      irq_stat <= 3'h0;
    end else begin
      flag_q   <= shutdown_status_flag;
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end

  assign IRQ = |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one registered ack with one wait state, dropped the cycle after
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK   <= req.cyc && req.stb && !WB_ACK;
      WB_DAT_O <= 32'h0000_0000;
      case (req.adr)
        `PDS_OFS_PWMCTL:   WB_DAT_O[7:0] <= {auto_restart_enable, deadband_count};
        `PDS_OFS_STEER:    WB_DAT_O[7:0] <= {3'b000, steer_sync_select, steer_req};
        `PDS_OFS_MODE:     WB_DAT_O[7:0] <= {output_config_select, 2'b00, module_mode_upper,
                                             output_polarity_select};
        `PDS_OFS_SHUT:     WB_DAT_O[7:0] <= {shutdown_status_flag, 3'b000, shut_state_ac, shut_state_bd};
        `PDS_OFS_PERIOD:   WB_DAT_O[7:0] <= period_limit;
        `PDS_OFS_DUTY:     WB_DAT_O[7:0] <= duty;
        `PDS_OFS_IRQ_STAT: WB_DAT_O[2:0] <= irq_stat;
        `PDS_OFS_IRQ_EN:   WB_DAT_O[2:0] <= irq_en;
        `PDS_OFS_PINDIR:   WB_DAT_O[3:0] <= pin_direction_control;
        default:           WB_DAT_O      <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_FALL_NODELAY: assert property (@(posedge MCLK) disable iff (!RESETN)
    !sched_a |=> !db_a) else $error("Dead band delayed a falling edge");
  AST_ZERO_DELAY: assert property (@(posedge MCLK) disable iff (!RESETN)
    (deadband_count == 7'h00 && $rose(sched_a)) |=> db_a) else $error("Zero count added delay");
  AST_RESTART: assert property (@(posedge MCLK) disable iff (!RESETN)
    (run && auto_restart_enable && !SHUTDOWN_IN && !ase_set_sw) |=> !shutdown_status_flag)
    else $error("Auto restart did not clear flag");
  AST_NO_RESTART: assert property (@(posedge MCLK) disable iff (!RESETN)
    (shutdown_status_flag && !auto_restart_enable && !ase_clr_sw) |=> shutdown_status_flag)
    else $error("Flag cleared without software");
  AST_SHUT_SET: assert property (@(posedge MCLK) disable iff (!RESETN)
    (run && SHUTDOWN_IN) |=> shutdown_status_flag) else $error("Shutdown flag not set");
  AST_STEER_IMM: assert property (@(posedge MCLK) disable iff (!RESETN)
    !steer_sync_select |=> steer_act == $past(steer_req)) else $error("Steering not immediate");
  AST_STEER_SYNC: assert property (@(posedge MCLK) disable iff (!RESETN)
    (steer_sync_select && !period_start && $past(steer_sync_select)) |=> $stable(steer_act))
    else $error("Steering changed mid period");
  AST_SLEEP_FREEZE: assert property (@(posedge MCLK) disable iff (!RESETN)
    (!run ##1 !run) |-> ($stable(PWM_OUT) && $stable(period_timer_count)))
    else $error("State moved in sleep");
  AST_PORT_PIN: assert property (@(posedge MCLK) disable iff (!RESETN)
    (run && !use_pwm[0]) |=> PWM_OUT[0] == $past(PORT_LATCH[0])) else $error("Port pin disturbed");

  COV_SHUT: cover property (@(posedge MCLK) disable iff (!RESETN) $rose(shutdown_status_flag));
  COV_RESTART: cover property (@(posedge MCLK) disable iff (!RESETN) $fell(held_off));
  COV_STEER4: cover property (@(posedge MCLK) disable iff (!RESETN) single_mode && steer_act == 4'hF);

endmodule

/* File: rtl/pds_consts.svh */
/*
  Constants for the PWM dead-band and steering output stage: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PDS_CONSTS_SVH
`define PDS_CONSTS_SVH

// Register word offsets (byte addresses on a 32-bit Wishbone bus)
`define PDS_OFS_PWMCTL    8'h00
`define PDS_OFS_STEER     8'h04
`define PDS_OFS_MODE      8'h08
`define PDS_OFS_SHUT      8'h0C
`define PDS_OFS_PERIOD    8'h10
`define PDS_OFS_DUTY      8'h14
`define PDS_OFS_IRQ_STAT  8'h18
`define PDS_OFS_IRQ_EN    8'h1C
`define PDS_OFS_IRQ_CLR   8'h20
`define PDS_OFS_PINDIR    8'h24

// Field positions
`define PDS_RESTART_BIT   7
`define PDS_SYNC_BIT      4
`define PDS_ASE_BIT       7
`define PDS_MODE_SINGLE   2'b11
`define PDS_CFG_SINGLE    2'b00
`define PDS_SHUT_LOW      2'b00
`define PDS_SHUT_HIGH     2'b01

// Reset values
`define PDS_STEER_RESET   8'h01
`define PDS_DIR_RESET     4'hF

// Instruction cycle is four oscillator periods
`define PDS_TOSC_PER_CYC  4

`endif

/* File: rtl/pds_pkg.sv */
/*
  Types for the PWM dead-band and steering output stage.
  Assumes the constants header is compiled alongside.
*/
package pds_pkg;

  // One set of four pin signals
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] drive;
  } pds_pins_type;

  // Power modes seen by the block
  typedef enum logic [1:0] {
    PDS_RUN,
    PDS_IDLE_PRI,
    PDS_IDLE_LP,
    PDS_SLEEP
  } pds_power_type;

  // Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pds_wb_req_type;

endpackage

/* File: rtl/pds_cycle_div.sv */
/*
  Instruction-cycle enable divider: one pulse every four master clocks,
  gated by the clock-run input.
  Assumes a single clock; the run input stops the count when low.
*/
`timescale 1ns/1ps
`include "pds_consts.svh"

module pds_cycle_div #(
  parameter int DIV = `PDS_TOSC_PER_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  // Enable out
  output logic      tick
);

  logic [7:0] cnt;

  // Free divider; holds while stopped so the phase survives a freeze
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
    end else if (run) begin
      cnt <= (cnt == 8'(DIV - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end

  assign tick = run && (cnt == 8'(DIV - 1));

endmodule

/* File: rtl/pds_deadband.sv */
/*
  Dead-band delay for one output: delays inactive-to-active edges by a count
  of instruction cycles, passes active-to-inactive edges at once.
  Assumes the input is an active-high scheduled waveform.
*/
`timescale 1ns/1ps

module pds_deadband (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Timing
  input  wire logic       tick,
  input  wire logic [6:0] count,
  // Waveform
  input  wire logic       sched,
  output logic            actual
);

  logic [6:0] wait_cnt;

  // Count down from the scheduled rise; falling edge cancels at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actual   <= 1'b0;
      wait_cnt <= 7'h00;
    end else if (!sched) begin
      actual   <= 1'b0;
      wait_cnt <= count;
    end else if (!actual) begin
      if (wait_cnt == 7'h00) begin
        actual <= 1'b1;
      end else if (tick) begin
        wait_cnt <= wait_cnt - 7'h01;
      end
    end
  end

endmodule

/* File: test/pds_switch_model.sv */
/*
  Model of the external power-switch drivers hung on the four PWM pins.
  Assumes pull-downs on every pin, so an undriven pin reads as a switch held off.
*/
`timescale 1ns/1ps

module pds_switch_model (
  // Clock
  input  wire logic       clk,
  // Bridge wiring: A is the upper switch, B the lower one
  input  wire logic       bridge,
  // Pins from the block
  input  wire logic [3:0] level,
  input  wire logic [3:0] drive,
  // Gate levels seen by the switches
  output logic [3:0]      gate,
  output int              overlaps
);

  ////////////////////////////////////////////////////////////////////////////////
  // A released pin falls to the pull-down level, never keeps its last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = drive[i] ? level[i] : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Both switches of one leg on together shorts the supply
  initial overlaps = 0;
  always @(posedge clk) begin
    if (bridge && gate[0] && gate[1]) begin
      overlaps <= overlaps + 1;
    end
  end
endmodule

/* File: test/pds_pwm_out_bench.sv */
/*
  Self-checking bench for the PWM output stage: registers over Wishbone,
  steering, sync, pin direction, shutdown and restart, power modes, dead band.
  Assumes the switch model beside the pins and a 20 MHz clock.
*/
`timescale 1ns/1ps
`include "pds_consts.svh"

module pds_pwm_out_bench;
  logic        mclk        = 1'b0;
  logic        resetn      = 1'b0;
  logic        cyc         = 1'b0;
  logic        stb         = 1'b0;
  logic        we          = 1'b0;
  logic [7:0]  adr         = 8'h00;
  logic [3:0]  sel         = 4'h0;
  logic [31:0] dat_i       = 32'h0000_0000;
  logic [1:0]  power_mode  = 2'b00;
  logic        shutdown_in = 1'b0;
  logic [3:0]  port_latch  = 4'h0;
  logic        bridge      = 1'b0;
  logic [31:0] dat_o;
  logic        ack;
  logic [3:0]  pwm_out;
  logic [3:0]  pwm_oe;
  logic        irq;
  logic [3:0]  gate;
  logic [31:0] rd;
  logic [31:0] s;
  logic [3:0]  p;
  int          overlaps;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          seed        = 32'he06b;
  int          g1;
  int          g2;
  int          n;
  int          ch;
  int          run_ch;

  // 50 ns period
  always #25 mclk = ~mclk;

  pds_pwm_out #(.LP_DIV(2)) pds_pwm_out_inst (
    .MCLK(mclk), .RESETN(resetn), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK(ack), .POWER_MODE(power_mode),
    .SHUTDOWN_IN(shutdown_in), .PORT_LATCH(port_latch), .PWM_OUT(pwm_out), .PWM_OE(pwm_oe), .IRQ(irq));

  pds_switch_model pds_switch_model_inst (
    .clk(mclk), .bridge(bridge), .level(pwm_out), .drive(pwm_oe), .gate(gate), .overlaps(overlaps));

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) begin
      check(32'h0000_0000, 32'h0000_0001);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // Steered pins carry the waveform with the A/C polarity, the others the port latch
  function automatic logic [3:0] steer_exp(logic [3:0] st, logic inv, logic act, logic [3:0] lat);
    for (int i = 0; i < 4; i++) begin
      steer_exp[i] = st[i] ? (act ^ inv) : lat[i];
    end
  endfunction

  // Cycles from the fall of one gate to the rise of the other
  task automatic gap_after(input int f, input int t, output int g);
    int k;
    k = 0;
    while (gate[f] !== 1'b1 && k < 300) begin @(posedge mclk); k++; end
    while (gate[f] !== 1'b0 && k < 600) begin @(posedge mclk); k++; end
    g = 0;
    while (gate[t] !== 1'b1 && g < 300) begin @(posedge mclk); g++; end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(4);
    resetn <= 1'b1;
    rd_chk(`PDS_OFS_STEER, 32'h0000_0001);
    rd_chk(`PDS_OFS_PWMCTL, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b1, `PDS_OFS_STEER, 32'h0000_00FF);
    rd_chk(`PDS_OFS_STEER, 32'h0000_001F);
    wb(1'b1, `PDS_OFS_PERIOD, 32'h0000_000F);
    wb(1'b1, `PDS_OFS_DUTY, 32'h0000_0020);
    wb(1'b1, `PDS_OFS_PINDIR, 32'h0000_0000);
    // Random steering masks, polarities and latches, immediate update; first mask empty
    for (int k = 0; k < 12; k++) begin
      s = $random(seed);
      if (k == 0) s[3:0] = 4'h0;
      port_latch <= s[11:8];
      wb(1'b1, `PDS_OFS_MODE, {28'h0000_000, 2'b11, s[5:4]});
      wb(1'b1, `PDS_OFS_STEER, {28'h0000_000, s[3:0]});
      idle(5);
      check(32'(gate), 32'(steer_exp(s[3:0], s[5], 1'b1, s[11:8])));
    end
    // Pins left as inputs never show the waveform
    wb(1'b1, `PDS_OFS_PINDIR, 32'h0000_0005);
    idle(5);
    check(32'(gate), 32'(steer_exp(s[3:0], s[5], 1'b1, s[11:8]) & 4'hA));
    // Synchronised steering waits for the next period start
    port_latch <= 4'h0;
    wb(1'b1, `PDS_OFS_PINDIR, 32'h0000_0000);
    wb(1'b1, `PDS_OFS_MODE, 32'h0000_000C);
    wb(1'b1, `PDS_OFS_STEER, 32'h0000_0011);
    wb(1'b1, `PDS_OFS_IRQ_EN, 32'h0000_0002);
    idle(80);
    wb(1'b1, `PDS_OFS_IRQ_CLR, 32'h0000_0007);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin @(posedge mclk); n++; end
    check(32'(irq), 32'h0000_0001);
    wb(1'b1, `PDS_OFS_STEER, 32'h0000_0012);
    idle(2);
    check(32'(gate), 32'h0000_0001);
    idle(80);
    check(32'(gate), 32'h0000_0002);
    // Shutdown: A/C forced high, B/D released, only steered pins touched
    wb(1'b1, `PDS_OFS_DUTY, 32'h0000_0000);
    wb(1'b1, `PDS_OFS_STEER, 32'h0000_0003);
    wb(1'b1, `PDS_OFS_SHUT, 32'h0000_0006);
    wb(1'b1, `PDS_OFS_IRQ_EN, 32'h0000_0001);
    wb(1'b1, `PDS_OFS_IRQ_CLR, 32'h0000_0007);
    port_latch <= 4'hC;
    idle(80);
    check(32'(gate), 32'h0000_000C);
    shutdown_in <= 1'b1;
    idle(3);
    check(32'(gate), 32'h0000_000D);
    check(32'(pwm_oe[1]), 32'h0000_0000);
    check(32'(irq), 32'h0000_0001);
    wb(1'b1, `PDS_OFS_SHUT, 32'h0000_0006);
    rd_chk(`PDS_OFS_SHUT, 32'h0000_0086);
    shutdown_in <= 1'b0;
    idle(150);
    rd_chk(`PDS_OFS_SHUT, 32'h0000_0086);
    check(32'(gate), 32'h0000_000D);
    wb(1'b1, `PDS_OFS_SHUT, 32'h0000_0006);
    idle(80);
    check(32'(gate), 32'h0000_000C);
    wb(1'b0, `PDS_OFS_IRQ_STAT, 32'h0000_0000);
    check(rd & 32'h0000_0005, 32'h0000_0005);
    wb(1'b1, `PDS_OFS_IRQ_CLR, 32'h0000_0007);
    idle(2);
    check(32'(irq), 32'h0000_0000);
    // Auto-restart with the interrupt masked
    wb(1'b1, `PDS_OFS_IRQ_EN, 32'h0000_0000);
    wb(1'b1, `PDS_OFS_PWMCTL, 32'h0000_0080);
    shutdown_in <= 1'b1;
    idle(5);
    check(32'(irq), 32'h0000_0000);
    shutdown_in <= 1'b0;
    idle(150);
    rd_chk(`PDS_OFS_SHUT, 32'h0000_0006);
    check(32'(gate), 32'h0000_000C);
    // Sleep freezes the pins; primary idle keeps full speed, low power runs slower
    wb(1'b1, `PDS_OFS_DUTY, 32'h0000_0008);
    wb(1'b1, `PDS_OFS_STEER, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      power_mode <= 2'(m == 0 ? 3 : m == 1 ? 1 : m == 2 ? 0 : 2);
      idle(2);
      p = gate;
      ch = 0;
      repeat (300) begin
        @(posedge mclk);
        if (gate !== p) ch++;
        p = gate;
      end
      if (m == 0) check(32'(ch), 32'h0000_0000);
      if (m == 1) check(32'(ch > 0), 32'h0000_0001);
      if (m == 2) run_ch = ch;
      if (m == 3) check(32'(ch < run_ch && ch > 0), 32'h0000_0001);
    end
    power_mode <= 2'b00;
    // Half-bridge dead band, zero count first
    bridge <= 1'b1;
    wb(1'b1, `PDS_OFS_MODE, 32'h0000_008C);
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 0 : 1 + ($unsigned($random(seed)) % 7);
      wb(1'b1, `PDS_OFS_PWMCTL, 32'(n));
      idle(130);
      gap_after(1, 0, g1);
      gap_after(0, 1, g2);
      check(32'(g1 >= 4 * n - 4 && g1 <= 4 * n + 4), 32'h0000_0001);
      check(32'(g2 >= 4 * n - 4 && g2 <= 4 * n + 4), 32'h0000_0001);
    end
    check(32'(overlaps), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
